/* core/epdrc_pkg.sv */
// Constants for the Ethernet power, debug-freeze, reset and pin-ownership block.
// Assumes a 32-bit APB register port with byte addresses.
package epdrc_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL1   = 8'h00;
  localparam logic [7:0]  OFF_EVT_EN  = 8'h04;
  localparam logic [7:0]  OFF_EVT_REQ = 8'h08;
  localparam logic [7:0]  OFF_STATUS  = 8'h0c;
  localparam logic [7:0]  OFF_SA0     = 8'h10;
  localparam logic [7:0]  OFF_SA1     = 8'h14;
  localparam logic [7:0]  OFF_SA2     = 8'h18;
  // ==========================================================================
  // Field positions
  localparam int          BIT_ON      = 15;
  localparam int          BIT_FREEZE  = 14;
  localparam int          BIT_IDLE_OFF = 13;
  localparam int          BIT_RX_DONE = 7;
  localparam int          BIT_RX_ACT  = 5;
  localparam int          ST_GATED    = 0;
  localparam int          ST_FROZEN   = 1;
  localparam int          ST_SLEEP    = 2;
  localparam int          ST_DEBUG    = 3;
  localparam int          ST_CNT_LSB  = 8;
  // ==========================================================================
  // Reset values and masks
  localparam logic [15:0] CTRL1_RST   = 16'h0000;
  localparam logic [15:0] CTRL1_WMASK = 16'ha000;
  localparam logic [15:0] EVT_EN_RST  = 16'h0000;
  localparam logic [15:0] EVT_MASK    = 16'h00a0;
  localparam logic [15:0] SA_RST      = 16'h0000;
  localparam logic [7:0]  CNT_RST     = 8'h00;
  // ==========================================================================
  // Pad indices of the driven interface pins
  localparam int          NUM_PADS    = 8;
  localparam int          PAD_MDC     = 0;
  localparam int          PAD_TXEN    = 1;
  localparam int          PAD_TXD0    = 2;
  localparam int          PAD_TXER    = 6;
  localparam int          PAD_MDIO    = 7;
  // ==========================================================================
  // Clock-power states
  typedef enum logic [1:0] {PWR_RUN, PWR_DRAIN, PWR_FROZEN, PWR_STOP} epdrc_pwr_e;
endpackage : epdrc_pkg

/* core/epdrc_clk_gate.sv */
// Glitch-free clock gate for the controller's internal clock.
// Assumes en comes from flip-flops on clk's rising edge.
`timescale 1ns/1ps
module epdrc_clk_gate (
  input  wire logic clk,
  input  wire logic en,
  output logic      gclk
);
  // ==========================================================================
  // Enable latch
  logic en_lat;

  // Transparent while clk is low, so gclk never sees a runt pulse
  always_latch begin
    if (!clk) begin
      en_lat <= en;
    end
  end

  assign gclk = clk & en_lat;
endmodule : epdrc_clk_gate

/* core/epdrc_top.sv */
// Power, debug-freeze, reset and pin-ownership control of a 10/100 Ethernet controller.
// Assumes pclk keeps running; link pins arrive asynchronously; CPU debug and power requests share pclk.
// Notes on behaviour
// [RQ1] Sleep stops all internal controller clocks; only link clocks keep running.
// [RQ2] A transfer caught by sleep is held frozen and resumes when the clock returns.
// [RQ3] While asleep an enabled asynchronous event raises the wake-up interrupt.
// [RQ4] Stop-in-idle clear: clocks stay on and operation continues in idle.
// [RQ5] Stop-in-idle set: idle gates clocks exactly like sleep.
// [RQ6] Receive-done flag, event bit 7, sets when the filters accept a packet.
// [RQ7] Receive-activity, event bit 5, stays high while the receive FIFO holds data.
// [RQ8] Software should enable another event, ideally receive-done, after disabling activity.
// [RQ9] Software should sleep only when disabled or with no pending traffic.
// [RQ10] Freeze clear: controller keeps running during a debug halt.
// [RQ11] Freeze set: finish bus transaction, then freeze and gate clocks until resume.
// [RQ12] While frozen registers stay readable and writable; reads have no side effects.
// [RQ13] Freeze bit is accessible only in debug mode and reads zero otherwise.
// [RQ14] Freeze writes act only after debug re-entry; reads give the entry value.
// [RQ15] While frozen, arriving frames may be discarded and transmits aborted.
// [RQ16] Device reset clears all fields and loads the factory station address.
// [RQ17] Device reset resets DMA engines, empties FIFOs, abandons transfers.
// [RQ18] Power-on and watchdog resets also force all registers to reset values.
// [RQ19] When on, the controller owns interface pin directions over the port settings.
// [RQ20] MII: PHY supplies clocks, receive and status lines; device drives transmit lines.
// [RQ21] RMII: reference clock, two data bits each way; management pins in both modes.
// [RQ22] Clock gating is glitch-free; link-side events are synchronised before use.
`timescale 1ns/1ps
module epdrc_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          por_n,
  input  wire logic                          wdt_rst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          sleep_req,
  input  wire logic                          idle_req,
  input  wire logic                          debug_mode,
  input  wire logic [47:0]                   factory_addr,
  input  wire logic                          rmii_mode,
  input  wire logic                          link_clk,
  input  wire logic                          link_rx_dv,
  input  wire logic                          link_rx_er,
  input  wire logic                          mdio_in,
  input  wire logic                          rx_filter_accept,
  input  wire logic                          rx_fifo_pop,
  input  wire logic                          core_mdc,
  input  wire logic                          core_mdo,
  input  wire logic                          core_mdo_en,
  input  wire logic                          core_txen,
  input  wire logic [3:0]                    core_txd,
  input  wire logic                          core_txer,
  input  wire logic [epdrc_pkg::NUM_PADS-1:0] gpio_out,
  input  wire logic [epdrc_pkg::NUM_PADS-1:0] gpio_oe_n,
  output logic      [epdrc_pkg::NUM_PADS-1:0] pad_out,
  output logic      [epdrc_pkg::NUM_PADS-1:0] pad_oe_n,
  output logic                               core_mdi,
  output logic                               core_clk,
  output logic                               core_rst_n,
  output logic                               ctrl_on,
  output logic      [47:0]                   station_addr,
  output logic                               event_pending,
  output logic                               wake_irq
);
  // ==========================================================================
  // Reset merge
  logic rst_n;
  // Any of the three reset sources clears everything asynchronously
  assign rst_n = presetn & por_n & wdt_rst_n; // [RQ16] [RQ18]

  // ==========================================================================
  // Declarations
  logic [15:0]          ctrl1_ff;
  logic [15:0]          evt_en_ff;
  logic                 rx_done_ff;
  logic                 freeze_wr_ff;
  logic                 freeze_cap_ff;
  logic                 dbg_d_ff;
  logic [15:0]          sa0_ff;
  logic [15:0]          sa1_ff;
  logic [15:0]          sa2_ff;
  logic                 sa_load_ff;
  logic                 core_rst_ff;
  logic [31:0]          prdata_ff;
  logic [7:0]           rx_cnt_ff;
  logic [2:0]           lclk_ff;
  logic [1:0]           dv_ff;
  logic [1:0]           er_ff;
  logic [1:0]           mdi_ff;
  logic                 dv_d_ff;
  logic                 er_seen_ff;
  epdrc_pkg::epdrc_pwr_e pwr_ff;
  epdrc_pkg::epdrc_pwr_e nxt_pwr;
  logic                 setup_ph;
  logic                 wr_acc;
  logic                 stop_req;
  logic                 freeze_req;
  logic                 frozen;
  logic                 link_rise;
  logic                 frame_end;
  logic                 rx_inc;
  logic                 rx_dec;
  logic                 rx_done_set;
  logic                 rx_done_clr;
  logic [15:0]          evt_req;
  logic                 mapped;
  logic [15:0]          rd_val;

  // ==========================================================================
  // APB decode: zero wait states, read data latched in the setup cycle
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign pready   = 1'b1;
  assign prdata   = prdata_ff;
  assign pslverr  = psel & penable & ~mapped;

  // Address check on the held address
  always_comb begin
    unique case (paddr)
      epdrc_pkg::OFF_CTRL1, epdrc_pkg::OFF_EVT_EN, epdrc_pkg::OFF_EVT_REQ, epdrc_pkg::OFF_STATUS,
      epdrc_pkg::OFF_SA0, epdrc_pkg::OFF_SA1, epdrc_pkg::OFF_SA2: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Read mux; freeze bit is visible only inside debug mode
  always_comb begin
    rd_val = 16'h0000;
    unique case (paddr)
      epdrc_pkg::OFF_CTRL1: begin
        rd_val = ctrl1_ff;
        rd_val[epdrc_pkg::BIT_FREEZE] = debug_mode & freeze_cap_ff; // [RQ13] [RQ14]
      end
      epdrc_pkg::OFF_EVT_EN:  rd_val = evt_en_ff;
      epdrc_pkg::OFF_EVT_REQ: rd_val = evt_req;
      epdrc_pkg::OFF_STATUS: begin
        rd_val[epdrc_pkg::ST_GATED]  = (pwr_ff == epdrc_pkg::PWR_STOP) | frozen;
        rd_val[epdrc_pkg::ST_FROZEN] = frozen;
        rd_val[epdrc_pkg::ST_SLEEP]  = pwr_ff == epdrc_pkg::PWR_STOP;
        rd_val[epdrc_pkg::ST_DEBUG]  = debug_mode;
        rd_val[epdrc_pkg::ST_CNT_LSB +: 8] = rx_cnt_ff;
      end
      epdrc_pkg::OFF_SA0: rd_val = sa0_ff;
      epdrc_pkg::OFF_SA1: rd_val = sa1_ff;
      epdrc_pkg::OFF_SA2: rd_val = sa2_ff;
      default: rd_val = 16'h0000;
    endcase
  end

  // Read data register; reads never touch block state, frozen or not
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_ff <= {16'h0000, rd_val}; // [RQ12]
    end
  end

  // ==========================================================================
  // Control register 1: on and stop-in-idle; writable even while frozen
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_ff <= epdrc_pkg::CTRL1_RST; // [RQ16]
    end else if (wr_acc && paddr == epdrc_pkg::OFF_CTRL1) begin
      ctrl1_ff <= pwdata[15:0] & epdrc_pkg::CTRL1_WMASK; // [RQ12]
    end
  end
  assign ctrl_on = ctrl1_ff[epdrc_pkg::BIT_ON];

  // Freeze bit: written only in debug, sampled into effect at debug entry
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      freeze_wr_ff  <= 1'b0;
      freeze_cap_ff <= 1'b0;
      dbg_d_ff      <= 1'b0;
    end else begin
      dbg_d_ff <= debug_mode;
      if (wr_acc && paddr == epdrc_pkg::OFF_CTRL1 && debug_mode) begin
        freeze_wr_ff <= pwdata[epdrc_pkg::BIT_FREEZE]; // [RQ13]
      end
      if (debug_mode && !dbg_d_ff) begin
        freeze_cap_ff <= freeze_wr_ff; // [RQ14]
      end
    end
  end

  // Event enable register
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_en_ff <= epdrc_pkg::EVT_EN_RST;
    end else if (wr_acc && paddr == epdrc_pkg::OFF_EVT_EN) begin
      evt_en_ff <= pwdata[15:0] & epdrc_pkg::EVT_MASK;
    end
  end

  // Station address: async reset to zero, factory value loaded right after release
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      sa_load_ff <= 1'b1;
      sa0_ff     <= epdrc_pkg::SA_RST;
      sa1_ff     <= epdrc_pkg::SA_RST;
      sa2_ff     <= epdrc_pkg::SA_RST;
    end else if (sa_load_ff) begin
      sa_load_ff <= 1'b0;
      sa0_ff     <= factory_addr[15:0]; // [RQ16]
      sa1_ff     <= factory_addr[31:16];
      sa2_ff     <= factory_addr[47:32];
    end else if (wr_acc) begin
      if (paddr == epdrc_pkg::OFF_SA0) sa0_ff <= pwdata[15:0];
      if (paddr == epdrc_pkg::OFF_SA1) sa1_ff <= pwdata[15:0];
      if (paddr == epdrc_pkg::OFF_SA2) sa2_ff <= pwdata[15:0];
    end
  end
  assign station_addr = {sa2_ff, sa1_ff, sa0_ff};

  // Controller core reset: held through reset and one edge after, flushing DMA and FIFOs
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      core_rst_ff <= 1'b0;
    end else begin
      core_rst_ff <= 1'b1; // [RQ17]
    end
  end
  assign core_rst_n = core_rst_ff;

  // ==========================================================================
  // Clock-power state machine
  assign stop_req   = sleep_req | (idle_req & ctrl1_ff[epdrc_pkg::BIT_IDLE_OFF]); // [RQ4] [RQ5]
  assign freeze_req = debug_mode & freeze_cap_ff; // [RQ10]
  assign frozen     = pwr_ff == epdrc_pkg::PWR_FROZEN;

  // Freeze waits for the bus transaction in flight; debug takes priority over sleep
  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      epdrc_pkg::PWR_RUN: begin
        if (freeze_req) nxt_pwr = epdrc_pkg::PWR_DRAIN;
        else if (stop_req) nxt_pwr = epdrc_pkg::PWR_STOP; // [RQ1] [RQ5]
      end
      epdrc_pkg::PWR_DRAIN: begin
        if (!freeze_req) nxt_pwr = epdrc_pkg::PWR_RUN;
        else if (!setup_ph) nxt_pwr = epdrc_pkg::PWR_FROZEN; // [RQ11]
      end
      epdrc_pkg::PWR_FROZEN: begin
        if (!debug_mode) nxt_pwr = epdrc_pkg::PWR_RUN; // [RQ11]
      end
      epdrc_pkg::PWR_STOP: begin
        if (freeze_req) nxt_pwr = epdrc_pkg::PWR_FROZEN;
        else if (!stop_req) nxt_pwr = epdrc_pkg::PWR_RUN; // [RQ2]
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff <= epdrc_pkg::PWR_RUN;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // Core clock gated in stop and freeze; the core simply holds its flops
  epdrc_clk_gate u_gate (
    .clk  (pclk),
    .en   (nxt_pwr == epdrc_pkg::PWR_RUN || nxt_pwr == epdrc_pkg::PWR_DRAIN), // [RQ1] [RQ2] [RQ22]
    .gclk (core_clk)
  );

  // ==========================================================================
  // Link-side sampling: two flops before any logic, then edge detect
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      lclk_ff <= 3'b000;
      dv_ff   <= 2'b00;
      er_ff   <= 2'b00;
      mdi_ff  <= 2'b00;
    end else begin
      lclk_ff <= {lclk_ff[1:0], link_clk}; // [RQ22]
      dv_ff   <= {dv_ff[0], link_rx_dv};
      er_ff   <= {er_ff[0], link_rx_er};
      mdi_ff  <= {mdi_ff[0], mdio_in};
    end
  end
  assign core_mdi  = mdi_ff[1];
  assign link_rise = lclk_ff[1] & ~lclk_ff[2];
  assign frame_end = link_rise & dv_d_ff & ~dv_ff[1];
  // Arrival and pop in one cycle cancel, so no pop is lost
  assign rx_inc    = link_rise & dv_ff[1] & ~frozen & (rx_cnt_ff != 8'hff); // [RQ15]
  assign rx_dec    = rx_fifo_pop & (rx_cnt_ff != epdrc_pkg::CNT_RST);

  // Receive data counter; arrivals dropped while frozen, emptied by reset
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_ff  <= epdrc_pkg::CNT_RST; // [RQ17]
      dv_d_ff    <= 1'b0;
      er_seen_ff <= 1'b0;
    end else begin
      if (link_rise) begin
        dv_d_ff <= dv_ff[1];
        er_seen_ff <= dv_ff[1] & (er_seen_ff | er_ff[1]);
      end
      if (rx_inc && !rx_dec) begin
        rx_cnt_ff <= rx_cnt_ff + 8'h01; // [RQ15]
      end else if (rx_dec && !rx_inc) begin
        rx_cnt_ff <= rx_cnt_ff - 8'h01;
      end
    end
  end

  // ==========================================================================
  // Event request flags: receive-done sticky, write one to clear, set wins
  assign rx_done_set = frame_end & rx_filter_accept & ~er_seen_ff & ~frozen; // [RQ6] [RQ15]
  assign rx_done_clr = wr_acc & (paddr == epdrc_pkg::OFF_EVT_REQ) & pwdata[epdrc_pkg::BIT_RX_DONE];

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_done_ff <= 1'b0;
    end else if (rx_done_set) begin
      rx_done_ff <= 1'b1; // [RQ6]
    end else if (rx_done_clr) begin
      rx_done_ff <= 1'b0;
    end
  end

  // Activity bit follows the FIFO level, so a write cannot clear it
  always_comb begin
    evt_req = 16'h0000;
    evt_req[epdrc_pkg::BIT_RX_DONE] = rx_done_ff;
    evt_req[epdrc_pkg::BIT_RX_ACT]  = rx_cnt_ff != epdrc_pkg::CNT_RST; // [RQ7]
  end

  // Wake only in the stop state, not while frozen; software must not leave activity as the sole source
  assign event_pending = |(evt_req & evt_en_ff);
  assign wake_irq      = event_pending & (pwr_ff == epdrc_pkg::PWR_STOP); // [RQ3] [RQ8]

  // ==========================================================================
  // Pin ownership: controller overrides port direction and latch when on
  always_comb begin
    pad_out  = gpio_out;
    pad_oe_n = gpio_oe_n;
    if (ctrl_on) begin // [RQ19]
      pad_out[epdrc_pkg::PAD_MDC]  = core_mdc; // [RQ21]
      pad_oe_n[epdrc_pkg::PAD_MDC] = 1'b0;
      pad_out[epdrc_pkg::PAD_TXEN]  = core_txen; // [RQ20]
      pad_oe_n[epdrc_pkg::PAD_TXEN] = 1'b0;
      pad_out[epdrc_pkg::PAD_TXD0 +: 4]  = rmii_mode ? {2'b00, core_txd[1:0]} : core_txd; // [RQ21]
      pad_oe_n[epdrc_pkg::PAD_TXD0 +: 4] = 4'h0;
      pad_out[epdrc_pkg::PAD_TXER]  = core_txer & ~rmii_mode;
      pad_oe_n[epdrc_pkg::PAD_TXER] = 1'b0;
      pad_out[epdrc_pkg::PAD_MDIO]  = core_mdo;
      pad_oe_n[epdrc_pkg::PAD_MDIO] = ~core_mdo_en;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!rst_n);

  a_sleep_gates: assert property (pwr_ff == epdrc_pkg::PWR_RUN && sleep_req && !freeze_req // [RQ1]
    |=> pwr_ff == epdrc_pkg::PWR_STOP)
    else $error("sleep did not stop the core clock");
  // Sampled at the falling edge, where a running core clock is high
  a_gate_off: assert property (@(negedge pclk) pwr_ff == epdrc_pkg::PWR_STOP // [RQ1]
    || pwr_ff == epdrc_pkg::PWR_FROZEN |-> !core_clk)
    else $error("core clock high while gated");
  a_stop_holds: assert property (pwr_ff == epdrc_pkg::PWR_STOP && stop_req && !freeze_req // [RQ2]
    |=> pwr_ff == epdrc_pkg::PWR_STOP)
    else $error("stop state left while still requested");
  a_wake_raise: assert property (pwr_ff == epdrc_pkg::PWR_STOP // [RQ3]
    && ((rx_done_ff && evt_en_ff[epdrc_pkg::BIT_RX_DONE])
    || (rx_cnt_ff != epdrc_pkg::CNT_RST && evt_en_ff[epdrc_pkg::BIT_RX_ACT])) |-> wake_irq)
    else $error("no wake on enabled event");
  a_idle_runs: assert property (pwr_ff == epdrc_pkg::PWR_RUN && idle_req && !sleep_req // [RQ4]
    && !ctrl1_ff[epdrc_pkg::BIT_IDLE_OFF] && !freeze_req |=> pwr_ff == epdrc_pkg::PWR_RUN)
    else $error("idle stopped with stop-in-idle clear");
  a_idle_stops: assert property (pwr_ff == epdrc_pkg::PWR_RUN && idle_req // [RQ5]
    && ctrl1_ff[epdrc_pkg::BIT_IDLE_OFF] && !freeze_req |=> pwr_ff == epdrc_pkg::PWR_STOP)
    else $error("idle ignored stop-in-idle");
  a_rx_done_sets: assert property (rx_done_set |=> evt_req[epdrc_pkg::BIT_RX_DONE]) // [RQ6]
    else $error("accepted packet did not set receive-done");
  a_rx_act_level: assert property ($past(rx_cnt_ff) != epdrc_pkg::CNT_RST && !$past(rx_fifo_pop) // [RQ7]
    |-> evt_req[epdrc_pkg::BIT_RX_ACT])
    else $error("activity dropped with data held");
  a_debug_drain: assert property (pwr_ff == epdrc_pkg::PWR_DRAIN && freeze_req && setup_ph // [RQ11]
    |=> pwr_ff == epdrc_pkg::PWR_DRAIN ##1 (pwr_ff == epdrc_pkg::PWR_FROZEN || !freeze_req))
    else $error("froze inside a bus transaction");
  a_freeze_reads0: assert property (setup_ph && !pwrite && paddr == epdrc_pkg::OFF_CTRL1 // [RQ13]
    && !debug_mode |=> !prdata[epdrc_pkg::BIT_FREEZE])
    else $error("freeze bit visible outside debug");
  a_freeze_stable: assert property (debug_mode && dbg_d_ff |=> $stable(freeze_cap_ff) || !debug_mode) // [RQ14]
    else $error("freeze changed within debug session");
  a_sa_factory: assert property (sa_load_ff |=> station_addr == $past(factory_addr)) // [RQ16]
    else $error("station address not loaded");
  a_pin_owned: assert property (ctrl_on |-> pad_oe_n[epdrc_pkg::PAD_TXEN] == 1'b0 // [RQ19]
    && pad_out[epdrc_pkg::PAD_TXEN] == core_txen)
    else $error("controller lost transmit enable pin");

  c_sleep:   cover property (pwr_ff == epdrc_pkg::PWR_RUN ##1 pwr_ff == epdrc_pkg::PWR_STOP);
  c_freeze:  cover property (pwr_ff == epdrc_pkg::PWR_DRAIN ##1 pwr_ff == epdrc_pkg::PWR_FROZEN);
  c_wake:    cover property ($rose(wake_irq));
  c_rx_done: cover property (rx_done_set && rx_done_clr);
endmodule : epdrc_top

/* verification/epdrc_phy_model.sv */
// Link partner: a PHY that sends receive frames on demand.
// Assumes go is raised on a pclk edge; its clock runs only within frames.
`timescale 1ns/1ps
module epdrc_phy_model (
  input  wire logic       go,
  input  wire logic [7:0] len,
  input  wire logic       bad,
  output logic            link_clk,
  output logic            link_rx_dv,
  output logic            link_rx_er,
  output logic            busy
);
  // ======
  // Idle link: clock stands still low outside frames
  initial begin
    link_clk   = 1'b0;
    link_rx_dv = 1'b0;
    link_rx_er = 1'b0;
    busy       = 1'b0;
  end
  // Frame: dv high for len rises, then one rise with dv low to end it
  always @(posedge go) begin
    busy = 1'b1;
    #7; // Offset keeps link edges away from pclk edges
    for (int i = 0; i <= int'(len); i++) begin
      link_rx_dv = (i < int'(len));
      link_rx_er = bad & (i == 0);
      #100 link_clk = 1'b1;
      #100 link_clk = 1'b0;
    end
    busy = 1'b0;
  end
endmodule : epdrc_phy_model

/* verification/epdrc_tb_top.sv */
// Self-checking bench: registers, events, gating, freeze, pins, resets.
// Assumes the core files and the link partner model compile first.
`timescale 1ns/1ps
module epdrc_tb_top;
  // ======
  // Stimulus and observation
  logic        pclk = 0, presetn = 0, por_n = 1, wdt_rst_n = 1, pwrite = 0, psel = 0;
  logic        penable = 0, sleep_req = 0, idle_req = 0, debug_mode = 0, rmii_mode = 0;
  logic        rx_filter_accept = 1, rx_fifo_pop = 0, go = 0, bad = 0, core_txen = 1;
  logic        core_txer = 1, pready, pslverr, core_mdi, core_clk, core_rst_n, ctrl_on;
  logic        event_pending, wake_irq, link_clk, link_rx_dv, link_rx_er, busy, e;
  logic [3:0]  core_txd = 4'hf;
  logic [7:0]  paddr = 8'h00, len = 8'h00, gpio_out = 8'h00, gpio_oe_n = 8'hff, pad_out, pad_oe_n;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [47:0] station_addr;
  logic [24:0] rows [8];
  int          err_total = 0, num_checks = 0, n, cycles = 0;

  epdrc_top epdrc_top_i (.pclk, .presetn, .por_n, .wdt_rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sleep_req, .idle_req, .debug_mode,
    .factory_addr(48'h0a0b_0c0d_0e0f), .rmii_mode, .link_clk, .link_rx_dv, .link_rx_er,
    .mdio_in(1'b1), .rx_filter_accept, .rx_fifo_pop, .core_mdc(1'b0), .core_mdo(1'b0),
    .core_mdo_en(1'b0), .core_txen, .core_txd, .core_txer, .gpio_out, .gpio_oe_n, .pad_out,
    .pad_oe_n, .core_mdi, .core_clk, .core_rst_n, .ctrl_on, .station_addr, .event_pending,
    .wake_irq);
  epdrc_phy_model epdrc_phy_model_i (.go, .len, .bad, .link_clk, .link_rx_dv, .link_rx_er, .busy);

  // ======
  // Clock and hang guard
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  // ======
  // Shared tasks
  task close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task chk(input logic [47:0] g, input logic [47:0] x);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  // Holds the whole request until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    cyc(1);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    cyc(1);
    penable <= 1'b1;
    cyc(1);
    while (pready !== 1'b1) cyc(1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [15:0] x);
    apb(1'b0, a, 16'h0000);
    chk(q, {16'h0000, x});
  endtask : rd
  // Counts gated-clock highs; skips the state change first
  task hi8(output int c);
    c = 0;
    cyc(4);
    repeat (8) begin
      @(posedge pclk);
      #1 c += int'(core_clk === 1'b1);
    end
    @(posedge pclk);
  endtask : hi8
  task frame(input logic [7:0] k);
    len <= k;
    go  <= 1'b1;
    cyc(2);
    go  <= 1'b0;
    while (busy === 1'b1) cyc(1);
    cyc(6);
  endtask : frame
  task pop;
    rx_fifo_pop <= 1'b1;
    cyc(1);
    rx_fifo_pop <= 1'b0;
    cyc(1);
  endtask : pop

  // ======
  // Main sequence: reset table, then hand-written cases
  initial begin
    rows = '{{1'b0, 8'h00, 16'h0000}, {1'b0, 8'h04, 16'h0000}, {1'b0, 8'h08, 16'h0000},
             {1'b0, 8'h0c, 16'h0000}, {1'b0, 8'h10, 16'h0e0f}, {1'b0, 8'h14, 16'h0c0d},
             {1'b0, 8'h18, 16'h0a0b}, {1'b1, 8'h1c, 16'h0000}};
    cyc(12);
    presetn <= 1'b1;
    cyc(2);
    chk(pad_oe_n, gpio_oe_n);
    foreach (rows[i]) begin
      rd(rows[i][23:16], rows[i][15:0]);
      chk(e, rows[i][24]);
    end
    chk(core_rst_n, 1'b1);
    chk(core_mdi, 1'b1);
    apb(1'b1, 8'h00, 16'he000);
    rd(8'h00, 16'ha000);
    chk(ctrl_on, 1'b1);
    chk(pad_oe_n[epdrc_pkg::PAD_TXEN], 1'b0);
    chk(pad_out[5:1], {core_txd, core_txen});
    rmii_mode <= 1'b1;
    cyc(1);
    chk(pad_out[6:4], 3'b000);
    rmii_mode <= 1'b0;
    apb(1'b1, 8'h04, 16'h0020);
    idle_req <= 1'b1;
    hi8(n);
    chk(n, 0);
    chk(wake_irq, 1'b0);
    frame(8'h03);
    chk(wake_irq, 1'b1);
    idle_req <= 1'b0;
    apb(1'b1, 8'h00, 16'h8000);
    idle_req <= 1'b1;
    hi8(n);
    chk(n, 8);
    idle_req <= 1'b0;
    rd(8'h0c, 16'h0300);
    rd(8'h08, 16'h00a0);
    apb(1'b1, 8'h08, 16'h00a0);
    rd(8'h08, 16'h0020);
    pop();
    pop();
    rd(8'h08, 16'h0020);
    pop();
    rd(8'h08, 16'h0000);
    chk(event_pending, 1'b0);
    sleep_req <= 1'b1;
    hi8(n);
    chk(n, 0);
    sleep_req <= 1'b0;
    debug_mode <= 1'b1;
    apb(1'b1, 8'h00, 16'hc000);
    rd(8'h00, 16'h8000);
    hi8(n);
    chk(n, 8);
    debug_mode <= 1'b0;
    cyc(2);
    debug_mode <= 1'b1;
    cyc(1);
    rd(8'h00, 16'hc000);
    hi8(n);
    chk(n, 0);
    frame(8'h02);
    rd(8'h0c, 16'h000b);
    rd(8'h0c, 16'h000b);
    apb(1'b1, 8'h04, 16'h0080);
    rd(8'h04, 16'h0080);
    debug_mode <= 1'b0;
    hi8(n);
    chk(n, 8);
    rd(8'h00, 16'h8000);
    frame(8'h02);
    rd(8'h08, 16'h00a0);
    wdt_rst_n <= 1'b0;
    cyc(2);
    chk(core_rst_n, 1'b0);
    wdt_rst_n <= 1'b1;
    cyc(2);
    rd(8'h00, 16'h0000);
    rd(8'h0c, 16'h0000);
    chk(station_addr, 48'h0a0b_0c0d_0e0f);
    close_out();
  end
endmodule : epdrc_tb_top
